/* File: common/spmc_map.vh */
// Register map, field positions and reset values of the servo port mode control block
`ifndef SPMC_MAP_VH
`define SPMC_MAP_VH

`define SPMC_OFS_MODE 20'hFD0A0
`define SPMC_OFS_DIR 20'hFD0A1
`define SPMC_OFS_DATA 20'hFD0A2
`define SPMC_OFS_MON 20'hFD0A3
`define SPMC_OFS_GAIN 20'hFD0A4

`define SPMC_RST_MODE 8'h40
`define SPMC_RST_DIR 8'hE0
`define SPMC_RST_DATA 8'hE0
`define SPMC_RST_MON 8'hC0
`define SPMC_RST_GAIN 8'hC0

`define SPMC_MODE_WMASK 8'hBF
`define SPMC_GP_MASK 8'h1F
`define SPMC_MON_MASK 8'h3F
`define SPMC_UNDEF_BYTE 8'h00

`define SPMC_BIT_HALT 7
`define SPMC_BIT_RSVD 6
`define SPMC_BIT_CAPSEL 5
`define SPMC_BIT_EXTTRK 4
`define SPMC_BIT_DRUMSEL 3
`define SPMC_BIT_COMPSW 2
`define SPMC_BIT_HAMPSW 1
`define SPMC_BIT_CROTSW 0

`define SPMC_MON_A_LSB 0
`define SPMC_MON_B_LSB 3
`define SPMC_MON_W 3
`define SPMC_GP_N 5
`define SPMC_PWM_W 12

`endif

/* File: src/spmc_servo_port.v */
// Servo port mode control: pin sharing, monitor selection and mode registers
//
// Function
// - Reset or standby loads the port mode register with its initial value 0x40.
// - Mode register bit 6 ignores writes; reading it gives 0.
// - Bit 7 zero runs control-track circuits; one halts them; reset zero.
// - Bit 5 zero picks comparator capstan path; one picks direct digital input.
// - Bit 4 chooses external track input or general-purpose line 4 on shared pin.
// - Drum frequency and phase tach taken separately or overlapped on one input.
// - Each monitor pin drives one of eight internal signals chosen by software.
// - Software sets the control-track input amplifier gain.
// - Capstan and drum drive outputs carry 12-bit PWM square waves.
// - Bit 4 zero selects external track input; one makes it general line 4.
// - Bit 3 zero gives separate drum inputs; one overlaps, freeing line 3.
// - In general-purpose use, direction bit one drives the pin, zero reads it.
`timescale 1ns/1ps
`default_nettype none
`include "spmc_map.vh"

module spmc_servo_port (
	input wire core_clk,
	input wire srst,
	input wire standby,
	input wire [19:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	input wire [4:0] gp_in,
	output wire [4:0] gp_out,
	output wire [4:0] gp_oe,
	input wire color_rotary_sig,
	input wire head_amp_switch_sig,
	output wire compare_in_sig,
	output wire external_track_input,
	input wire drum_frequency_tach,
	output wire drum_phase_tach,
	output wire drum_freq_to_servo,
	output wire drum_overlap_mode,
	input wire capstan_comparator_in,
	input wire capstan_digital_in,
	output wire capstan_tach_sel,
	output wire track_circuit_halt,
	output wire [7:0] track_amp_gain_out,
	input wire [7:0] monitor_sources,
	output reg monitor_out_a,
	output reg monitor_out_b,
	input wire [11:0] capstan_duty,
	input wire [11:0] drum_duty,
	output reg capstan_drive_out,
	output reg drum_drive_out
);

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	reg [7:0] servo_port_mode_r;
	reg [7:0] servo_pin_direction_r;
	reg [7:0] servo_pin_data_r;
	reg [7:0] monitor_output_select_r;
	reg [7:0] track_amp_gain_r;
	reg [11:0] pwm_cnt_r;
	reg [4:0] gp_sel;
	reg [7:0] pin_read;
	integer i;

	function [7:0] pick_src;
		input [7:0] src;
		input [2:0] sel;
		begin
			pick_src = {7'h00, src[sel]};
		end
	endfunction

	wire rst_any = srst | standby;
	wire wr_mode = reg_wr && (reg_addr == `SPMC_OFS_MODE);
	wire wr_dir = reg_wr && (reg_addr == `SPMC_OFS_DIR);
	wire wr_data = reg_wr && (reg_addr == `SPMC_OFS_DATA);
	wire wr_mon = reg_wr && (reg_addr == `SPMC_OFS_MON);
	wire wr_gain = reg_wr && (reg_addr == `SPMC_OFS_GAIN);

	always @(posedge core_clk) begin
		if (rst_any) begin
			servo_port_mode_r <= `SPMC_RST_MODE;
			servo_pin_direction_r <= `SPMC_RST_DIR;
			servo_pin_data_r <= `SPMC_RST_DATA;
			monitor_output_select_r <= `SPMC_RST_MON;
			track_amp_gain_r <= `SPMC_RST_GAIN;
		end else begin
			// Reserved bits keep their reset ones
			if (wr_mode) begin
				servo_port_mode_r <= (reg_wdata & `SPMC_MODE_WMASK) |
					(`SPMC_RST_MODE & ~`SPMC_MODE_WMASK);
			end
			if (wr_dir) begin
				servo_pin_direction_r <= (reg_wdata & `SPMC_GP_MASK) |
					(`SPMC_RST_DIR & ~`SPMC_GP_MASK);
			end
			if (wr_data) begin
				servo_pin_data_r <= (reg_wdata & `SPMC_GP_MASK) |
					(`SPMC_RST_DATA & ~`SPMC_GP_MASK);
			end
			if (wr_mon) begin
				monitor_output_select_r <= (reg_wdata & `SPMC_MON_MASK) |
					(`SPMC_RST_MON & ~`SPMC_MON_MASK);
			end
			if (wr_gain) begin
				track_amp_gain_r <= reg_wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin sharing

	always @* begin
		gp_sel = {servo_port_mode_r[`SPMC_BIT_EXTTRK], servo_port_mode_r[`SPMC_BIT_DRUMSEL],
			servo_port_mode_r[`SPMC_BIT_COMPSW], servo_port_mode_r[`SPMC_BIT_HAMPSW],
			servo_port_mode_r[`SPMC_BIT_CROTSW]};
	end

	genvar g;
	generate
		for (g = 0; g < `SPMC_GP_N; g = g + 1) begin : gp_pin
			// Output-only servo functions on lines 0 and 1 drive in servo mode
			wire svc_drive = (g == 0 || g == 1) && !gp_sel[g];
			wire svc_val = (g == 0) ? color_rotary_sig : head_amp_switch_sig;
			assign gp_oe[g] = svc_drive | (gp_sel[g] & servo_pin_direction_r[g]);
			assign gp_out[g] = svc_drive ? svc_val : servo_pin_data_r[g];
		end
	endgenerate

	assign compare_in_sig = gp_sel[`SPMC_BIT_COMPSW] ? 1'b0 : gp_in[`SPMC_BIT_COMPSW];
	assign external_track_input = gp_sel[`SPMC_BIT_EXTTRK] ? 1'b0 :
		gp_in[`SPMC_BIT_EXTTRK];
	// Overlapped mode carries both tach signals on the frequency input
	assign drum_overlap_mode = servo_port_mode_r[`SPMC_BIT_DRUMSEL];
	assign drum_phase_tach = gp_sel[`SPMC_BIT_DRUMSEL] ? 1'b0 :
		gp_in[`SPMC_BIT_DRUMSEL];
	assign drum_freq_to_servo = drum_frequency_tach;
	assign capstan_tach_sel = servo_port_mode_r[`SPMC_BIT_CAPSEL] ?
		capstan_digital_in : capstan_comparator_in;
	assign track_circuit_halt = servo_port_mode_r[`SPMC_BIT_HALT];
	assign track_amp_gain_out = track_amp_gain_r;

	////////////////////////////////////////////////////////////////////////////////
	// Monitor outputs and PWM drives

	always @(posedge core_clk) begin
		if (rst_any) begin
			monitor_out_a <= 1'b0;
			monitor_out_b <= 1'b0;
			pwm_cnt_r <= 12'h000;
			capstan_drive_out <= 1'b0;
			drum_drive_out <= 1'b0;
		end else begin
			monitor_out_a <= pick_src(monitor_sources,
				monitor_output_select_r[`SPMC_MON_A_LSB +: `SPMC_MON_W]) != 8'h00;
			monitor_out_b <= pick_src(monitor_sources,
				monitor_output_select_r[`SPMC_MON_B_LSB +: `SPMC_MON_W]) != 8'h00;
			pwm_cnt_r <= pwm_cnt_r + 12'h001;
			capstan_drive_out <= (pwm_cnt_r < capstan_duty);
			drum_drive_out <= (pwm_cnt_r < drum_duty);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path

	always @* begin
		pin_read = servo_pin_data_r;
		for (i = 0; i < `SPMC_GP_N; i = i + 1) begin
			if (!servo_pin_direction_r[i]) begin
				pin_read[i] = gp_in[i];
			end
		end
	end

	always @(posedge core_clk) begin
		if (rst_any) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`SPMC_OFS_MODE: reg_rdata <= servo_port_mode_r & `SPMC_MODE_WMASK;
				`SPMC_OFS_DATA: reg_rdata <= pin_read & `SPMC_GP_MASK;
				`SPMC_OFS_MON: reg_rdata <= monitor_output_select_r & `SPMC_MON_MASK;
				`SPMC_OFS_GAIN: reg_rdata <= track_amp_gain_r;
				default: reg_rdata <= `SPMC_UNDEF_BYTE;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule // spmc_servo_port
`default_nettype wire

/* File: testbench/spmc_far_side.sv */
// Far-side model: drum and capstan tach, monitor sources, shared pin levels
`timescale 1ns/1ps
`default_nettype none
module spmc_far_side (
	input wire logic core_clk,
	input wire logic [4:0] gp_out, gp_oe, pin_lvl,
	output logic [4:0] gp_in,
	output logic [7:0] monitor_sources,
	output logic drum_frequency_tach, capstan_comparator_in, capstan_digital_in
);
	logic [7:0] cnt = 8'h00;
	always @(posedge core_clk) cnt <= cnt + 8'h01;
	// Sources move every cycle so a stale monitor selection shows
	assign monitor_sources = cnt ^ 8'h5A;
	assign drum_frequency_tach = cnt[2];
	assign capstan_comparator_in = cnt[1];
	assign capstan_digital_in = !cnt[1];
	assign gp_in = (gp_oe & gp_out) | (~gp_oe & pin_lvl);
endmodule // spmc_far_side
`default_nettype wire

/* File: testbench/spmc_port_assertions.sv */
// Port checks of the servo port mode control block
`timescale 1ns/1ps
`default_nettype none
`include "spmc_map.vh"
module spmc_port_chk (
	input wire core_clk, srst, standby, reg_wr, reg_rd, track_circuit_halt,
	input wire external_track_input, drum_overlap_mode,
	input wire [19:0] reg_addr,
	input wire [7:0] reg_wdata, reg_rdata, track_amp_gain_out,
	input wire [4:0] gp_in, gp_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	wire wm = reg_wr && !standby && reg_addr == `SPMC_OFS_MODE;
	a_halt_set: assert property (wm |=> track_circuit_halt == $past(reg_wdata[7]))
		else $error("halt");
	a_halt_hold: assert property (!wm && !standby |=> $stable(track_circuit_halt))
		else $error("hold");
	a_ext_gate: assert property (wm |=> external_track_input == (!$past(reg_wdata[4]) && gp_in[4]))
		else $error("ext");
	a_drum_ovl: assert property (wm |=> drum_overlap_mode == $past(reg_wdata[3]))
		else $error("ovl");
	a_servo_input: assert property (wm && !reg_wdata[4] |=> !gp_oe[4])
		else $error("oe");
	a_rsvd_read: assert property (reg_rd && reg_addr == `SPMC_OFS_MODE |=> !reg_rdata[6])
		else $error("bit6");
	a_gain_set: assert property (reg_wr && !standby && reg_addr == `SPMC_OFS_GAIN
		|=> track_amp_gain_out == $past(reg_wdata)) else $error("gain");
	a_standby_init: assert property (standby |=> !track_circuit_halt
		&& track_amp_gain_out == `SPMC_RST_GAIN) else $error("standby");
endmodule // spmc_port_chk
bind spmc_servo_port spmc_port_chk u_chk (.*);
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench, servo port mode control
`timescale 1ns/1ps
`default_nettype none
`include "spmc_map.vh"
module testbench;
	logic core_clk = 0, srst = 1, standby = 0, reg_wr = 0, reg_rd = 0;
	logic color_rotary_sig = 0, head_amp_switch_sig = 0;
	logic [19:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, m, d, s;
	logic [11:0] capstan_duty = 0, drum_duty = 0;
	logic [4:0] pin_lvl = 0;
	logic [31:0] lf = 32'h03E96FE3;
	wire [7:0] reg_rdata, track_amp_gain_out, monitor_sources;
	wire [4:0] gp_in, gp_out, gp_oe;
	wire compare_in_sig, external_track_input, drum_frequency_tach, drum_phase_tach;
	wire drum_freq_to_servo, drum_overlap_mode, capstan_comparator_in, capstan_digital_in;
	wire capstan_tach_sel, track_circuit_halt, monitor_out_a, monitor_out_b;
	wire capstan_drive_out, drum_drive_out;
	int n_errors = 0, num_checks = 0, cyc = 0, i, hc, hd;
	spmc_servo_port u_dut (.*);
	spmc_far_side u_far (.*);
	initial forever #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) if (++cyc > 20000) begin
		n_errors++;
		report_and_stop;
	end
	function automatic logic [31:0] nx(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Servo lines 0 and 1 are outputs, the rest inputs, unless freed
	function automatic logic [4:0] oe_exp(input logic [7:0] md, dr);
		return (md[4:0] & dr[4:0]) | (~md[4:0] & 5'h03);
	endfunction
	task chk(input logic [11:0] g, e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: %h, expected %h", $time, g, e);
		end
	endtask
	// A write, or a read whose data is compared with x the cycle after
	task acc(input logic w, input logic [19:0] a, input logic [7:0] x);
		@(posedge core_clk);
		{reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, x};
		@(posedge core_clk);
		{reg_wr, reg_rd} <= 2'b00;
		#1;
		if (!w) chk(reg_rdata, x);
	endtask
	task report_and_stop;
		if (n_errors == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		acc(0, `SPMC_OFS_MODE, 8'h00);
		for (i = 0; i < 40; i++) begin
			m = i < 2 ? {3'h7, i[0] ? 5'h1F : 5'h00} : lf[7:0];
			d = lf[15:8];
			{pin_lvl, color_rotary_sig, head_amp_switch_sig} <= lf[22:16];
			lf = nx(lf);
			acc(1, `SPMC_OFS_MODE, m);
			acc(1, `SPMC_OFS_DIR, d);
			acc(1, `SPMC_OFS_DATA, lf[7:0]);
			chk({track_circuit_halt, drum_overlap_mode}, {m[7], m[3]});
			chk(capstan_tach_sel, m[5] ? capstan_digital_in : capstan_comparator_in);
			chk({external_track_input, drum_phase_tach}, {~m[4] & gp_in[4], ~m[3] & gp_in[3]});
			chk(gp_oe, oe_exp(m, d));
			chk(gp_out, {lf[4:2], m[1] ? lf[1] : head_amp_switch_sig, m[0] ? lf[0] : color_rotary_sig});
			chk({compare_in_sig, drum_freq_to_servo}, {~m[2] & gp_in[2], drum_frequency_tach});
			acc(0, `SPMC_OFS_MODE, m & `SPMC_MODE_WMASK);
			acc(0, `SPMC_OFS_DATA, {3'h0, (d[4:0] & lf[4:0]) | (~d[4:0] & gp_in)});
			acc(0, i[0] ? `SPMC_OFS_DIR : 20'hFD0A5, 8'h00);
			acc(1, `SPMC_OFS_MON, d);
			s = monitor_sources;
			@(posedge core_clk);
			#1;
			chk({monitor_out_a, monitor_out_b}, {s[d[2:0]], s[d[5:3]]});
			acc(1, `SPMC_OFS_GAIN, m);
			chk(track_amp_gain_out, m);
		end
		@(posedge core_clk);
		standby <= 1'b1;
		@(posedge core_clk);
		standby <= 1'b0;
		#1;
		chk({track_circuit_halt, track_amp_gain_out}, {1'b0, `SPMC_RST_GAIN});
		for (i = 0; i < 2; i++) begin
			{capstan_duty, drum_duty} <= i ? 24'hFFF000 : lf[23:0];
			repeat (3) @(posedge core_clk);
			{hc, hd} = 0;
			repeat (4096) @(posedge core_clk) {hc, hd} = {hc + capstan_drive_out, hd + drum_drive_out};
			chk({hc[11:0]}, capstan_duty);
			chk({hd[11:0]}, drum_duty);
		end
		report_and_stop;
	end
endmodule // testbench
`default_nettype wire
